// ---- rtl/channel_divider_config.sv ----
// Clock source selection, prescaler and two cascaded divider channels,
// configured through a four-wire serial control port.
// Assumes all pins are asynchronous to i_clk and far slower than it.
//
// Overview of operation
// - Low count sets output low time.
// - High count sets output high time.
// - Shared register holds both stage phase offsets.
// - Second-stage bypass passes input, idles divider.
// - First-stage bypass passes input, idles divider.
// - Sync-ignore bit decides sync participation.
// - Force bit sets static level during soft sync with sync-ignore.
// - Start bits choose each stage's first level.
// - Duty correction active while disable bit clear.
// - Prescaler divides 2 to 6, else static.
// - Section power-down stops buffer, prescaler, tree.
// - Combined power-down stops oscillator and input.
// - Source select: external input or oscillator.
// - Prescaler bypass routes external input around divider.
// - Soft sync holds dividers, release restarts them.
// - Settings other than soft sync take effect only after update bit.
`include "channel_divider_config_defines.svh"

module channel_divider_config (
  input  wire logic       i_clk,      // System clock, 250 MHz
  input  wire logic       i_reset,    // Asynchronous reset, active high
  input  wire logic       i_sclk,     // Serial port clock pin
  input  wire logic       i_sdio,     // Serial port data in pin
  input  wire logic       i_cs_n,     // Serial port select pin, active low
  input  wire logic       i_ext_clk,  // External clock input pin
  input  wire logic       i_osc_clk,  // Internal oscillator clock
  output logic            o_sdo,      // Serial read data
  output logic [1:0]      o_ch_out,   // Channel outputs, index 0 is channel 2
  output logic            o_ext_pd,   // External input buffer powered down
  output logic            o_osc_pd,   // Internal oscillator powered down
  output logic            o_osc_if_pd,// Oscillator interface powered down
  output logic            o_section_pd// Clock input section powered down
);

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  localparam int PINS = 5;
  logic [PINS-1:0] pin_raw;
  logic [PINS-1:0] pin_meta;
  logic [PINS-1:0] pin_sync;

  assign pin_raw = {i_osc_clk, i_ext_clk, i_cs_n, i_sdio, i_sclk};

  for (genvar p = 0; p < PINS; p++) begin : g_sync
    always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
        pin_meta[p] <= 1'b0;
        pin_sync[p] <= 1'b0;
      end else begin
        pin_meta[p] <= pin_raw[p];
        pin_sync[p] <= pin_meta[p];
      end
    end
  end

  logic sclk_prev;
  logic sclk_rise;
  logic sclk_fall;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= pin_sync[0];
    end
  end

  assign sclk_rise = pin_sync[0] & ~sclk_prev;
  assign sclk_fall = ~pin_sync[0] & sclk_prev;

  // ------------------------------------------------------------------
  // Serial control port
  // ------------------------------------------------------------------
  // Frames are 16 instruction bits then 8 data bits, MSB first.
  logic [22:0] shift;
  logic [4:0]  bit_cnt;
  logic [23:0] frame;
  logic [7:0]  rd_shift;
  logic        reading;
  logic        wr_strobe;

  channel_divider_config_pkg::cfg_t buf_cfg;
  channel_divider_config_pkg::cfg_t act;
  logic                             soft_sync;
  logic                             update_pending;

  assign frame     = {shift, pin_sync[1]};
  assign wr_strobe = sclk_rise && !pin_sync[2] && bit_cnt == `SPI_LAST_FRAME_BIT && !frame[23];

  function automatic logic [7:0] read_reg(input logic [12:0] addr);
    logic [7:0] d;
    d = 8'h00;
    unique case (addr)
      `ADDR_CH2_FIRST_COUNTS:  d = buf_cfg.ch[0].first_counts;
      `ADDR_CH2_PHASE:         d = buf_cfg.ch[0].phase;
      `ADDR_CH2_SECOND_COUNTS: d = buf_cfg.ch[0].second_counts;
      `ADDR_CH2_CONTROL:       d = buf_cfg.ch[0].control;
      `ADDR_CH2_DUTY:          d = buf_cfg.ch[0].duty;
      `ADDR_CH3_FIRST_COUNTS:  d = buf_cfg.ch[1].first_counts;
      `ADDR_CH3_PHASE:         d = buf_cfg.ch[1].phase;
      `ADDR_CH3_SECOND_COUNTS: d = buf_cfg.ch[1].second_counts;
      `ADDR_CH3_CONTROL:       d = buf_cfg.ch[1].control;
      `ADDR_CH3_DUTY:          d = buf_cfg.ch[1].duty;
      `ADDR_PRESCALER_RATIO:   d = buf_cfg.prescale;
      `ADDR_CLOCK_INPUT_CTRL:  d = buf_cfg.clkin;
      `ADDR_SOFT_SYNC:         d = {7'h00, soft_sync};
      `ADDR_UPDATE:            d = {7'h00, update_pending};
      default:                 d = 8'h00;
    endcase
    return d;
  endfunction

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      shift    <= 23'h000000;
      bit_cnt  <= 5'h00;
      rd_shift <= 8'h00;
      reading  <= 1'b0;
      o_sdo    <= 1'b0;
    end else if (pin_sync[2]) begin
      // Deselect aborts any partial frame.
      bit_cnt <= 5'h00;
      reading <= 1'b0;
      o_sdo   <= 1'b0;
    end else if (sclk_rise) begin
      shift   <= frame[22:0];
      bit_cnt <= (bit_cnt == `SPI_LAST_FRAME_BIT) ? 5'h00 : bit_cnt + 5'h01;
      if (bit_cnt == `SPI_LAST_INSTR_BIT) begin
        reading  <= frame[15];
        rd_shift <= read_reg(frame[12:0]);
      end else if (bit_cnt == `SPI_LAST_FRAME_BIT) begin
        reading <= 1'b0;
      end
    end else if (sclk_fall && reading) begin
      o_sdo    <= rd_shift[7];
      rd_shift <= {rd_shift[6:0], 1'b0};
    end else if (sclk_fall) begin
      o_sdo <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Buffer and active registers
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      buf_cfg   <= {12{`RESET_CFG_BYTE}};
      soft_sync <= `RESET_SOFT_SYNC;
    end else if (wr_strobe) begin
      unique case (frame[20:8])
        `ADDR_CH2_FIRST_COUNTS:  buf_cfg.ch[0].first_counts  <= frame[7:0];
        `ADDR_CH2_PHASE:         buf_cfg.ch[0].phase         <= frame[7:0];
        `ADDR_CH2_SECOND_COUNTS: buf_cfg.ch[0].second_counts <= frame[7:0];
        `ADDR_CH2_CONTROL:       buf_cfg.ch[0].control       <= frame[7:0];
        `ADDR_CH2_DUTY:          buf_cfg.ch[0].duty          <= frame[7:0];
        `ADDR_CH3_FIRST_COUNTS:  buf_cfg.ch[1].first_counts  <= frame[7:0];
        `ADDR_CH3_PHASE:         buf_cfg.ch[1].phase         <= frame[7:0];
        `ADDR_CH3_SECOND_COUNTS: buf_cfg.ch[1].second_counts <= frame[7:0];
        `ADDR_CH3_CONTROL:       buf_cfg.ch[1].control       <= frame[7:0];
        `ADDR_CH3_DUTY:          buf_cfg.ch[1].duty          <= frame[7:0];
        `ADDR_PRESCALER_RATIO:   buf_cfg.prescale            <= frame[7:0];
        `ADDR_CLOCK_INPUT_CTRL:  buf_cfg.clkin               <= frame[7:0];
        `ADDR_SOFT_SYNC:         soft_sync <= frame[`SOFT_SYNC_BIT];
        default: ;
      endcase
    end
  end

  // A new request on the same edge as a copy wins, so it is never lost.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      update_pending <= 1'b0;
      act            <= {12{`RESET_CFG_BYTE}};
    end else begin
      if (sclk_rise && update_pending) begin
        act <= buf_cfg;
      end
      if (wr_strobe && frame[20:8] == `ADDR_UPDATE && frame[`UPDATE_BIT]) begin
        update_pending <= 1'b1;
      end else if (sclk_rise) begin
        update_pending <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Source selection and prescaler
  // ------------------------------------------------------------------
  logic       section_pd;
  logic       osc_path;
  logic       ext_path;
  logic       src_lvl;
  logic [3:0] ratio;
  logic [3:0] pre_cnt;
  logic [3:0] next_pre_cnt;
  logic       pre_static;
  logic       pre_bypass;
  logic       src_prev;
  logic       pre_lvl;
  logic       dist_lvl;
  logic       dist_prev;
  logic       dist_tick;

  assign section_pd = act.clkin[`CLKIN_SECTION_PD_BIT];
  assign osc_path   = pin_sync[4] & ~act.clkin[`CLKIN_BOTH_PD_BIT]
                      & ~act.clkin[`CLKIN_OSC_IF_PD_BIT];
  assign ext_path   = pin_sync[3] & ~act.clkin[`CLKIN_BOTH_PD_BIT] & ~section_pd;
  assign src_lvl    = act.clkin[`CLKIN_SRC_SEL_BIT] ? osc_path : ext_path;
  assign ratio      = {1'b0, act.prescale[2:0]} + `PRESCALE_MIN_RATIO;
  assign pre_static = act.prescale[2:0] > `PRESCALE_MAX_CODE;
  // Bypass with the oscillator selected is not allowed, so it is ignored.
  assign pre_bypass = act.clkin[`CLKIN_PRE_BYPASS_BIT]
                      & ~act.clkin[`CLKIN_SRC_SEL_BIT];
  assign next_pre_cnt = (pre_cnt >= ratio - 4'h1) ? 4'h0 : pre_cnt + 4'h1;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      src_prev <= 1'b0;
      pre_cnt  <= 4'h0;
      pre_lvl  <= 1'b0;
    end else if (section_pd || pre_static) begin
      src_prev <= src_lvl;
      pre_cnt  <= 4'h0;
      pre_lvl  <= 1'b0;
    end else begin
      src_prev <= src_lvl;
      if (src_lvl && !src_prev) begin
        pre_cnt <= next_pre_cnt;
        pre_lvl <= next_pre_cnt < (ratio >> 1);
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      dist_lvl  <= 1'b0;
      dist_prev <= 1'b0;
    end else begin
      dist_lvl  <= ~section_pd & (pre_bypass ? src_lvl : pre_lvl);
      dist_prev <= dist_lvl;
    end
  end

  assign dist_tick = dist_lvl & ~dist_prev;

  // ------------------------------------------------------------------
  // Sync control
  // ------------------------------------------------------------------
  logic soft_prev;
  logic sync_release;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      soft_prev <= `RESET_SOFT_SYNC;
    end else begin
      soft_prev <= soft_sync;
    end
  end

  assign sync_release = soft_prev & ~soft_sync;

  // ------------------------------------------------------------------
  // Cascaded channel dividers
  // ------------------------------------------------------------------
  logic [1:0][1:0] stage_lvl;
  logic [1:0][1:0] stage_prev;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic nosync;
    logic dcc_off;
    assign nosync  = act.ch[c].control[`CTRL_NOSYNC_BIT];
    assign dcc_off = act.ch[c].duty[`DUTY_CORR_OFF_BIT];

    for (genvar s = 0; s < 2; s++) begin : g_stage
      logic [7:0] counts;
      logic [3:0] phase;
      logic       bypass;
      logic       start;
      logic       in_lvl;
      logic       in_tick;
      logic [4:0] hi_raw;
      logic [4:0] lo_raw;
      logic [5:0] total;
      logic [5:0] hi;
      logic [5:0] lo;
      logic [5:0] cnt;
      logic       lvl;

      assign counts  = (s == 0) ? act.ch[c].first_counts : act.ch[c].second_counts;
      assign phase   = (s == 0) ? act.ch[c].phase[3:0] : act.ch[c].phase[7:4];
      assign bypass  = act.ch[c].control[`CTRL_BYPASS_BASE_BIT + s];
      assign start   = act.ch[c].control[`CTRL_START_BASE_BIT + s];
      // The second stage runs from the first stage's output edges.
      assign in_lvl  = (s == 0) ? dist_lvl : stage_lvl[c][0];
      assign in_tick = (s == 0) ? dist_tick : (stage_lvl[c][0] & ~stage_prev[c][0]);
      assign hi_raw  = {1'b0, counts[3:0]} + 5'h01;
      assign lo_raw  = {1'b0, counts[7:4]} + 5'h01;
      assign total   = {1'b0, hi_raw} + {1'b0, lo_raw};
      // Correction keeps the period and splits it as evenly as it can.
      assign hi      = dcc_off ? {1'b0, hi_raw} : (total + 6'h01) >> 1;
      assign lo      = dcc_off ? {1'b0, lo_raw} : total - ((total + 6'h01) >> 1);

      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          lvl <= 1'b0;
          cnt <= 6'h00;
        end else if (bypass) begin
          lvl <= 1'b0;
          cnt <= 6'h00;
        end else if (!nosync && (soft_sync || sync_release)) begin
          lvl <= start;
          cnt <= {2'h0, phase} + (start ? hi : lo) - 6'h01;
        end else if (in_tick) begin
          if (cnt == 6'h00) begin
            lvl <= ~lvl;
            cnt <= (lvl ? lo : hi) - 6'h01;
          end else begin
            cnt <= cnt - 6'h01;
          end
        end
      end

      assign stage_lvl[c][s] = bypass ? in_lvl : lvl;

      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          stage_prev[c][s] <= 1'b0;
        end else begin
          stage_prev[c][s] <= stage_lvl[c][s];
        end
      end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
        o_ch_out[c] <= 1'b0;
      end else if (section_pd) begin
        o_ch_out[c] <= 1'b0;
      end else if (nosync && soft_sync) begin
        o_ch_out[c] <= act.ch[c].control[`CTRL_FORCE_BIT];
      end else begin
        o_ch_out[c] <= stage_lvl[c][1];
      end
    end
  end

  // ------------------------------------------------------------------
  // Power-down status pins
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_ext_pd     <= 1'b0;
      o_osc_pd     <= 1'b0;
      o_osc_if_pd  <= 1'b0;
      o_section_pd <= 1'b0;
    end else begin
      o_ext_pd     <= act.clkin[`CLKIN_BOTH_PD_BIT] | section_pd;
      o_osc_pd     <= act.clkin[`CLKIN_BOTH_PD_BIT];
      o_osc_if_pd  <= act.clkin[`CLKIN_OSC_IF_PD_BIT];
      o_section_pd <= section_pd;
    end
  end

endmodule

// ---- rtl/channel_divider_config_defines.svh ----
// Register offsets, field positions, reset values and frame sizes for the
// channel divider configuration block.
// Assumes inclusion by bare name from the design files.
`ifndef CHANNEL_DIVIDER_CONFIG_DEFINES_SVH
`define CHANNEL_DIVIDER_CONFIG_DEFINES_SVH

`define ADDR_CH2_FIRST_COUNTS   13'h199
`define ADDR_CH2_PHASE          13'h19A
`define ADDR_CH2_SECOND_COUNTS  13'h19B
`define ADDR_CH2_CONTROL        13'h19C
`define ADDR_CH2_DUTY           13'h19D
`define ADDR_CH3_FIRST_COUNTS   13'h19E
`define ADDR_CH3_PHASE          13'h19F
`define ADDR_CH3_SECOND_COUNTS  13'h1A0
`define ADDR_CH3_CONTROL        13'h1A1
`define ADDR_CH3_DUTY           13'h1A2
`define ADDR_PRESCALER_RATIO    13'h1E0
`define ADDR_CLOCK_INPUT_CTRL   13'h1E1
`define ADDR_SOFT_SYNC          13'h230
`define ADDR_UPDATE             13'h232

`define CTRL_BYPASS_BASE_BIT    4
`define CTRL_NOSYNC_BIT         3
`define CTRL_FORCE_BIT          2
`define CTRL_START_BASE_BIT     0
`define DUTY_CORR_OFF_BIT       0
`define CLKIN_SECTION_PD_BIT    4
`define CLKIN_OSC_IF_PD_BIT     3
`define CLKIN_BOTH_PD_BIT       2
`define CLKIN_SRC_SEL_BIT       1
`define CLKIN_PRE_BYPASS_BIT    0
`define SOFT_SYNC_BIT           0
`define UPDATE_BIT              0

`define PRESCALE_MAX_CODE       3'h4
`define PRESCALE_MIN_RATIO      4'h2
`define RESET_CFG_BYTE          8'h00
`define RESET_SOFT_SYNC         1'b0

`define SPI_LAST_INSTR_BIT      5'h0F
`define SPI_LAST_FRAME_BIT      5'h17

`endif

// ---- rtl/channel_divider_config_pkg.sv ----
// Types shared by the channel divider configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
package channel_divider_config_pkg;

  typedef struct packed {
    logic [7:0] duty;
    logic [7:0] control;
    logic [7:0] second_counts;
    logic [7:0] phase;
    logic [7:0] first_counts;
  } chan_cfg_t;

  typedef struct packed {
    chan_cfg_t [1:0] ch;
    logic [7:0]      clkin;
    logic [7:0]      prescale;
  } cfg_t;

endpackage

// ---- tb/channel_divider_config_chk.sv ----
// Port-level checker for the channel divider configuration block.
// Assumes it is bound to every instance of channel_divider_config.
module channel_divider_config_chk (
  input wire logic       i_clk,        // System clock
  input wire logic       i_reset,      // Asynchronous reset, active high
  input wire logic       i_sclk,       // Serial clock pin
  input wire logic       i_cs_n,       // Serial select pin, active low
  input wire logic       i_ext_clk,    // External clock pin
  input wire logic       i_osc_clk,    // Internal oscillator clock
  input wire logic [1:0] o_ch_out,     // Channel outputs
  input wire logic       o_ext_pd,     // External input powered down
  input wire logic       o_osc_pd,     // Oscillator powered down
  input wire logic       o_osc_if_pd,  // Oscillator interface powered down
  input wire logic       o_section_pd  // Input section powered down
);
  // ----------------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------------
  logic [3:0] since_rise;
  logic [4:0] quiet;

  // Both counters restart at reset, so the settling that follows a release
  // is never mistaken for a change without a cause.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      since_rise <= 4'h0;
    end else if ($rose(i_sclk)) begin
      since_rise <= 4'h0;
    end else if (since_rise != 4'hF) begin
      since_rise <= since_rise + 4'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      quiet <= 5'h00;
    end else if ($changed({i_sclk, i_cs_n, i_ext_clk, i_osc_clk})) begin
      quiet <= 5'h00;
    end else if (quiet != 5'h1F) begin
      quiet <= quiet + 5'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_osc_pd_ext: assert property (o_osc_pd |-> o_ext_pd)
    else $error("combined power-down left the input running");
  a_sect_pd_ext: assert property (o_section_pd |-> o_ext_pd)
    else $error("section power-down left the input buffer running");
  a_sect_out_low: assert property (o_section_pd [*4] |-> o_ch_out == 2'b00)
    else $error("channel output active in powered-down section");
  a_sect_on_sclk: assert property ($changed(o_section_pd) |-> since_rise < 4'hA)
    else $error("section power-down moved without a serial edge");
  a_ifpd_on_sclk: assert property (since_rise > 4'hA |-> $stable(o_osc_if_pd))
    else $error("interface power-down moved without a serial edge");
  a_oscpd_on_sclk: assert property ($changed(o_osc_pd) |-> since_rise < 4'hA)
    else $error("oscillator power-down moved without a serial edge");
  a_quiet_hold: assert property (quiet > 5'h10 |-> $stable(o_ch_out))
    else $error("channel output moved with no source edge");
  a_dead_source: assert property (o_osc_pd && $past(o_osc_pd, 8) && since_rise == 4'hF
                                  |-> $stable(o_ch_out))
    else $error("channel output moved with both sources down");

  c_section: cover property (o_section_pd [*4]);
  c_osc_pd: cover property (o_osc_pd && since_rise == 4'hF);
  c_quiet: cover property (quiet > 5'h10);
  c_toggle: cover property ($rose(o_ch_out[1]));
endmodule

bind channel_divider_config channel_divider_config_chk i_channel_divider_config_chk (
  .i_clk        (i_clk),
  .i_reset      (i_reset),
  .i_sclk       (i_sclk),
  .i_cs_n       (i_cs_n),
  .i_ext_clk    (i_ext_clk),
  .i_osc_clk    (i_osc_clk),
  .o_ch_out     (o_ch_out),
  .o_ext_pd     (o_ext_pd),
  .o_osc_pd     (o_osc_pd),
  .o_osc_if_pd  (o_osc_if_pd),
  .o_section_pd (o_section_pd)
);

// ---- tb/tb_channel_divider_config.sv ----
// Self-checking bench for the channel divider configuration block.
// Assumes the design files and the bound checker are compiled before it.
`include "channel_divider_config_defines.svh"

module tb_channel_divider_config;
  timeunit 1ns;
  timeprecision 100ps;

  logic       i_clk = 1'b0;
  logic       i_reset = 1'b1;
  logic       i_sclk = 1'b0;
  logic       i_sdio = 1'b0;
  logic       i_cs_n = 1'b1;
  logic       i_ext_clk = 1'b0;
  logic       i_osc_clk = 1'b0;
  logic       o_sdo;
  logic [1:0] o_ch_out;
  logic       o_ext_pd;
  logic       o_osc_pd;
  logic       o_osc_if_pd;
  logic       o_section_pd;
  logic       run = 1'b1;
  logic [3:0] e_cnt = 4'h0;
  logic [3:0] o_cnt = 4'h0;
  int         err_count = 0;
  int         samples_checked = 0;
  int         cycles = 0;

  always #2 i_clk = ~i_clk;

  // ----------------------------------------------------------------------
  // Sources and timeout
  // ----------------------------------------------------------------------
  // Phases of 8 and 12 cycles keep each level far above the synchroniser.
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    e_cnt <= (e_cnt == 4'h7) ? 4'h0 : e_cnt + 4'h1;
    o_cnt <= (o_cnt == 4'hB) ? 4'h0 : o_cnt + 4'h1;
    if (run && e_cnt == 4'h7) i_ext_clk <= ~i_ext_clk;
    if (run && o_cnt == 4'hB) i_osc_clk <= ~i_osc_clk;
    if (cycles == 90000) begin
      err_count++;
      $display("BAD %0t run did not finish", $time);
      wrap_up();
    end
  end

  channel_divider_config i_channel_divider_config (
    .i_clk        (i_clk),
    .i_reset      (i_reset),
    .i_sclk       (i_sclk),
    .i_sdio       (i_sdio),
    .i_cs_n       (i_cs_n),
    .i_ext_clk    (i_ext_clk),
    .i_osc_clk    (i_osc_clk),
    .o_sdo        (o_sdo),
    .o_ch_out     (o_ch_out),
    .o_ext_pd     (o_ext_pd),
    .o_osc_pd     (o_osc_pd),
    .o_osc_if_pd  (o_osc_if_pd),
    .o_section_pd (o_section_pd)
  );

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bits past the 24th are zero; they only give an update its extra edge.
  task automatic xfer(input logic [23:0] w, input int n, output logic [7:0] q);
    q = 8'h00;
    repeat (4) @(posedge i_clk);
    i_cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      i_sclk <= 1'b0;
      i_sdio <= (i < 24) ? w[23 - i] : 1'b0;
      repeat (5) @(posedge i_clk);
      @(negedge i_clk);
      if (i >= 16) q = {q[6:0], o_sdo};
      @(posedge i_clk);
      i_sclk <= 1'b1;
      repeat (6) @(posedge i_clk);
    end
    i_sclk <= 1'b0;
    i_cs_n <= 1'b1;
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] x;
    xfer({3'b000, a, d}, 24, x);
  endtask

  task automatic rd(input logic [12:0] a, output logic [7:0] d);
    xfer({3'b100, a, 8'h00}, 24, d);
  endtask

  task automatic upd;
    logic [7:0] x;
    xfer({3'b000, `ADDR_UPDATE, 8'h01}, 25, x);
  endtask

  task automatic run_len(input int ch, input logic v, input int lim, output int n);
    n = 0;
    while (o_ch_out[ch] === v && n < lim) begin
      @(negedge i_clk);
      n++;
    end
  endtask

  // The first periods after a change are skipped; they may mix old settings.
  task automatic per(input int ch, input int hi, input int lo);
    int h;
    int l;
    for (int k = 0; k < 2; k++) begin
      run_len(ch, 1'b1, 3000, h);
      run_len(ch, 1'b0, 3000, h);
    end
    run_len(ch, 1'b1, 3000, h);
    run_len(ch, 1'b0, 3000, l);
    chk(h, hi);
    chk(l, lo);
  endtask

  task automatic hold(input int ch, input logic v);
    int n;
    repeat (20) @(negedge i_clk);
    run_len(ch, v, 200, n);
    chk(n, 200);
  endtask

  task automatic cfg(input logic [7:0] ci, input logic [7:0] pr, input logic [7:0] ct,
                     input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] du);
    wr(`ADDR_CLOCK_INPUT_CTRL, ci);
    wr(`ADDR_PRESCALER_RATIO, pr);
    wr(`ADDR_CH2_CONTROL, ct);
    wr(`ADDR_CH2_FIRST_COUNTS, c1);
    wr(`ADDR_CH2_SECOND_COUNTS, c2);
    wr(`ADDR_CH2_DUTY, du);
    upd();
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs;
    logic [12:0] al [12] = '{`ADDR_CH2_FIRST_COUNTS, `ADDR_CH2_PHASE, `ADDR_CH2_SECOND_COUNTS,
      `ADDR_CH2_CONTROL, `ADDR_CH2_DUTY, `ADDR_CH3_FIRST_COUNTS, `ADDR_CH3_PHASE,
      `ADDR_CH3_SECOND_COUNTS, `ADDR_CH3_CONTROL, `ADDR_CH3_DUTY, `ADDR_PRESCALER_RATIO,
      `ADDR_CLOCK_INPUT_CTRL};
    logic [7:0] d;
    foreach (al[i]) begin
      rd(al[i], d);
      chk(d, 8'h00);
      wr(al[i], al[i][7:0] ^ 8'hA5);
      rd(al[i], d);
      chk(d, al[i][7:0] ^ 8'hA5);
    end
    wr(13'h1A3, 8'h5A);
    rd(13'h1A3, d);
    chk(d, 8'h00);
  endtask

  // The clock input byte now buffers 0x44, which asks for combined power-down.
  task automatic t_pd;
    @(negedge i_clk);
    chk(o_osc_pd, 1'b0);
    upd();
    repeat (40) @(negedge i_clk);
    chk({o_osc_pd, o_ext_pd, o_section_pd, o_osc_if_pd}, 4'b1100);
    wr(`ADDR_CLOCK_INPUT_CTRL, 8'h18);
    upd();
    repeat (40) @(negedge i_clk);
    chk({o_osc_pd, o_ext_pd, o_section_pd, o_osc_if_pd}, 4'b0111);
    hold(0, 1'b0);
    @(posedge i_clk);
    run <= 1'b0;
    repeat (40) @(posedge i_clk);
    run <= 1'b1;
  endtask

  task automatic t_stages;
    cfg(8'h01, 8'h00, 8'h20, 8'h21, 8'h00, 8'h01);
    per(0, 32, 48);
    cfg(8'h01, 8'h00, 8'h20, 8'h21, 8'h00, 8'h00);
    per(0, 48, 32);
    cfg(8'h01, 8'h00, 8'h00, 8'h00, 8'h10, 8'h01);
    per(0, 32, 64);
    cfg(8'h01, 8'h00, 8'h30, 8'h21, 8'h21, 8'h01);
    per(0, 8, 8);
  endtask

  task automatic t_prescale;
    int r;
    for (int c = 0; c < 8; c++) begin
      r = c + 2;
      cfg(8'h00, c[7:0], 8'h30, 8'h00, 8'h00, 8'h01);
      if (c < 5) per(0, (r / 2) * 16, (r - r / 2) * 16);
      else hold(0, 1'b0);
    end
  endtask

  // The oscillator is only ever selected with the prescaler in the path.
  task automatic t_source;
    cfg(8'h02, 8'h01, 8'h30, 8'h00, 8'h00, 8'h01);
    per(0, 24, 48);
  endtask

  task automatic t_sync;
    int n;
    wr(`ADDR_CH3_CONTROL, 8'h2C);
    wr(`ADDR_CH2_PHASE, 8'h0F);
    cfg(8'h01, 8'h00, 8'h21, 8'h22, 8'h00, 8'h01);
    wr(`ADDR_SOFT_SYNC, 8'h01);
    hold(0, 1'b1);
    hold(1, 1'b1);
    wr(`ADDR_CH2_CONTROL, 8'h20);
    wr(`ADDR_CH3_CONTROL, 8'h28);
    upd();
    hold(0, 1'b0);
    hold(1, 1'b0);
    wr(`ADDR_SOFT_SYNC, 8'h00);
    // The first low after release spans a phase of 15 plus 3 low input periods
    // of 16 clocks, less the few clocks of serial and sync latency.
    @(negedge i_clk);
    run_len(0, 1'b0, 400, n);
    chk(n > 260 && n < 300, 1'b1);
    per(0, 48, 48);
  endtask

  task automatic t_ch3;
    wr(`ADDR_CH3_FIRST_COUNTS, 8'h10);
    wr(`ADDR_CH3_CONTROL, 8'h20);
    wr(`ADDR_CH3_DUTY, 8'h01);
    upd();
    per(1, 16, 32);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (4) @(posedge i_clk);
    t_regs();
    t_pd();
    t_stages();
    t_prescale();
    t_source();
    t_sync();
    t_ch3();
    wrap_up();
  end
endmodule
